// [design/break_mask_and_modem_sequencer.sv]
// break mask gating and modem connect/disconnect sequencer
//
// Contract
// R1 - with mask bit 0 and bit 6 set, a uart parity, overrun or framing error raises a break.
// R2 - bit 3 enables break on interval expiry, bit 2 on alarm match, bit 1 on plug-in interrupt.
// R3 - the mask-set command loads all eight mask bits straight from its operand.
// R4 - no source raises a break unless master enable bit 6 is set.
// R5 - modem mode keeps all direct sources and adds break events for the disconnect sequences.
// R6 - on power-on in modem mode terminal ready and request to send are asserted.
// R7 - the modem asserts clear to send and data set ready on a call, then carrier detect.
// R8 - if the three modem lines are not all up within 20 s, the disconnect sequence starts.
// R9 - the disconnect sequence drops terminal ready for 6 s.
// R10 - commands from the controller and front panel are refused during the hold.
// R11 - once connected, carrier, data set ready or terminal ready down 300 ms disconnects.
// R12 - in modem mode the device is the terminal side and answers incoming calls.
// R13 - the device never originates or dials a call.
// R14 - with mask bit 5 and bit 6 set, power-up or extender recovery raises a break; in the code power-up never does, the mask still being 8'h00.
// R15 - with mask bit 4 and bit 6 set, a message that cannot be executed raises a break.
// R16 - after the hold, terminal ready returns and the device waits again, mask unchanged.
`timescale 1ns/10ps
`default_nettype none
`include "break_modem_defines.svh"

module break_mask_and_modem_sequencer #(
    parameter logic [31:0] WAIT_CYCLES = `CONNECT_WAIT_CYC,
    parameter logic [31:0] HOLD_CYCLES = `HOLD_CYC,
    parameter logic [31:0] LOSS_CYCLES = `LOSS_CYC
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // mask-set command
    input wire logic mask_wr_in,
    input wire break_modem_pkg::mask_type mask_data_in,
    // event sources, one-cycle pulses on this clock
    input wire logic uart_parity_err_in,
    input wire logic uart_overrun_err_in,
    input wire logic uart_framing_err_in,
    input wire logic digital_intr_in,
    input wire logic alarm_match_in,
    input wire logic interval_expired_in,
    input wire logic msg_not_exec_in,
    input wire logic extender_recovered_in,
    // mode select, static configuration on this clock
    input wire logic modem_mode_in,
    // modem status pins, asynchronous
    input wire logic cts_in,
    input wire logic dsr_in,
    input wire logic dcd_in,
    // modem control pins and status
    output logic dtr_out,
    output logic rts_out,
    output logic break_out,
    output logic cmd_refuse_out,
    output logic connected_out
);

    import break_modem_pkg::*;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // a zero count would make the compare below wait for an all-ones timer
    if (WAIT_CYCLES == 32'h0000_0000) begin : g_bad_wait
        $error("WAIT_CYCLES must be at least one");
    end
    if (HOLD_CYCLES == 32'h0000_0000) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end
    if (LOSS_CYCLES == 32'h0000_0000) begin : g_bad_loss
        $error("LOSS_CYCLES must be at least one");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    mask_type mask_q;
    modem_state_type state_q;
    modem_state_type state_d;
    logic [31:0] timer_q;
    logic timer_clr;
    logic pon_pend_q;
    logic break_q;
    logic dtr_q;
    logic rts_q;
    logic refuse_q;
    logic connected_q;
    lines_type lines_clean;
    logic lines_all_up;
    logic line_lost;
    logic io_err;
    logic pon_evt;
    logic disc_evt;
    logic src_hit;

    // ----------------------------------------
    // modem line synchroniser
    // ----------------------------------------
    modem_lines_if lines_if ();

    // gather pins into the carrier
    assign lines_if.raw[`LINE_CTS] = cts_in;
    assign lines_if.raw[`LINE_DSR] = dsr_in;
    assign lines_if.raw[`LINE_DCD] = dcd_in;
    assign lines_clean = lines_if.clean;

    modem_line_filter u_filter (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .lines(lines_if.sync)
    );

    // the modem raises these on an incoming call (see R7)
    assign lines_all_up = &lines_clean;
    // own terminal ready is counted too, though it never drops while connected
    assign line_lost = !lines_clean[`LINE_DCD]
        || !lines_clean[`LINE_DSR]
        || !dtr_q; // see R11

    // ----------------------------------------
    // interrupt mask
    // ----------------------------------------
    // whole operand replaces the mask; refused while the hold runs
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            mask_q <= `MASK_RESET;
        end else if (mask_wr_in && !refuse_q) begin // see R10
            mask_q <= mask_data_in; // see R3
        end
    end

    // ----------------------------------------
    // power-on event
    // ----------------------------------------
    // one event in the first cycle after reset release
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            pon_pend_q <= 1'b1;
        end else begin
            pon_pend_q <= 1'b0;
        end
    end

    assign pon_evt = pon_pend_q || extender_recovered_in;

    // ----------------------------------------
    // break source gating
    // ----------------------------------------
    assign io_err = uart_parity_err_in || uart_overrun_err_in || uart_framing_err_in;

    // disconnect starts are extra sources only in modem mode
    assign disc_evt = (state_q != ST_HOLD) && (state_d == ST_HOLD); // see R5

    // each direct source needs a mask bit, bit 0 serving all three uart errors; disconnect starts need none
    always_comb begin
        src_hit = 1'b0;
        if (mask_q[`MASK_IO_ERR_BIT] && io_err) begin // see R1
            src_hit = 1'b1;
        end
        if (mask_q[`MASK_DIG_BIT] && digital_intr_in) begin // see R2
            src_hit = 1'b1;
        end
        if (mask_q[`MASK_ALARM_BIT] && alarm_match_in) begin // see R2
            src_hit = 1'b1;
        end
        if (mask_q[`MASK_INTERVAL_BIT] && interval_expired_in) begin // see R2
            src_hit = 1'b1;
        end
        if (mask_q[`MASK_MSG_BIT] && msg_not_exec_in) begin // see R15
            src_hit = 1'b1;
        end
        if (mask_q[`MASK_PON_BIT] && pon_evt) begin // see R14
            src_hit = 1'b1;
        end
        if (disc_evt) begin // see R5
            src_hit = 1'b1;
        end
    end

    // master enable gates every source, one-cycle break pulse
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            break_q <= 1'b0;
        end else begin
            break_q <= mask_q[`MASK_MASTER_BIT] && src_hit; // see R4
        end
    end

    // ----------------------------------------
    // modem sequencer
    // ----------------------------------------
    // direct: lines idle, only the mask sources count
    // wait: answer side, counting the connect window
    // connected: loss count runs while carrier, data set ready or terminal ready is down
    // hold: terminal ready down, commands refused
    // leaving modem mode from any state drops straight back to direct
    // the device only answers; no state ever drives a call out
    always_comb begin
        state_d = state_q;
        timer_clr = 1'b0;
        unique case (state_q)
            ST_DIRECT: begin
                if (modem_mode_in) begin
                    state_d = ST_WAIT; // see R6
                end
            end
            ST_WAIT: begin
                // answer side: wait for the remote to call in (see R12, R13)
                if (lines_all_up) begin
                    state_d = ST_CONNECTED;
                end else if (timer_q == WAIT_CYCLES - 32'h0000_0001) begin
                    state_d = ST_HOLD; // see R8
                end
            end
            ST_CONNECTED: begin
                // loss must be continuous; any recovery restarts the count
                if (!line_lost) begin
                    timer_clr = 1'b1;
                end else if (timer_q == LOSS_CYCLES - 32'h0000_0001) begin
                    state_d = ST_HOLD; // see R11
                end
            end
            ST_HOLD: begin
                if (timer_q == HOLD_CYCLES - 32'h0000_0001) begin
                    state_d = ST_WAIT; // see R16
                end
            end
        endcase
        // leaving modem mode aborts the sequence at once
        if (!modem_mode_in) begin
            state_d = ST_DIRECT;
        end
    end

    // state register
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state_q <= ST_DIRECT;
        end else begin
            state_q <= state_d;
        end
    end

    // one shared timer, restarted on every state change
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            timer_q <= 32'h0000_0000;
        end else if (state_d != state_q || timer_clr) begin
            timer_q <= 32'h0000_0000;
        end else if (state_q != ST_DIRECT) begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // modem control outputs
    // ----------------------------------------
    // terminal ready, registered from the next state so the pin moves with it
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            dtr_q <= 1'b0;
        end else begin
            // down only in the hold and in direct mode
            dtr_q <= (state_d == ST_WAIT) || (state_d == ST_CONNECTED); // see R6, R9
        end
    end

    // request to send stays up through the hold; the modem watches terminal ready
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            rts_q <= 1'b0;
        end else begin
            rts_q <= (state_d != ST_DIRECT); // see R6
        end
    end

    // command refusal follows the hold exactly
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            refuse_q <= 1'b0;
        end else begin
            refuse_q <= (state_d == ST_HOLD); // see R10
        end
    end

    // connection status for the host side
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            connected_q <= 1'b0;
        end else begin
            connected_q <= (state_d == ST_CONNECTED);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign dtr_out = dtr_q;
    assign rts_out = rts_q;
    assign break_out = break_q;
    assign cmd_refuse_out = refuse_q; // front panel and serial parser both obey it
    assign connected_out = connected_q;

endmodule

`default_nettype wire

// [inc/break_modem_defines.svh]
// constants for the break mask and modem sequencer
`ifndef BREAK_MODEM_DEFINES_SVH
`define BREAK_MODEM_DEFINES_SVH

// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_HZ 25000000
`define CONNECT_WAIT_S 20
`define HOLD_S 6
`define LOSS_MS 300
`define CONNECT_WAIT_CYC (`CONNECT_WAIT_S * `CLK_HZ)
`define HOLD_CYC (`HOLD_S * `CLK_HZ)
`define LOSS_CYC ((`CLK_HZ / 1000) * `LOSS_MS)

// ----------------------------------------
// mask layout
// ----------------------------------------
`define MASK_W 8
`define MASK_RESET 8'h00
`define MASK_IO_ERR_BIT 0
`define MASK_DIG_BIT 1
`define MASK_ALARM_BIT 2
`define MASK_INTERVAL_BIT 3
`define MASK_MSG_BIT 4
`define MASK_PON_BIT 5
`define MASK_MASTER_BIT 6

// ----------------------------------------
// modem line indices
// ----------------------------------------
`define LINE_COUNT 3
`define LINE_CTS 0
`define LINE_DSR 1
`define LINE_DCD 2

`endif

// [inc/break_modem_pkg.sv]
// types shared by the break mask and modem sequencer
`include "break_modem_defines.svh"

package break_modem_pkg;
    typedef logic [`MASK_W-1:0] mask_type;
    typedef logic [`LINE_COUNT-1:0] lines_type;
    typedef enum logic [1:0] {
        ST_DIRECT,
        ST_WAIT,
        ST_CONNECTED,
        ST_HOLD
    } modem_state_type;
endpackage

// [inc/modem_lines_if.sv]
// modem status lines, raw from the pins and filtered
`timescale 1ns/10ps
`default_nettype none
`include "break_modem_defines.svh"

interface modem_lines_if;
    logic [`LINE_COUNT-1:0] raw;
    logic [`LINE_COUNT-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

`default_nettype wire

// [design/modem_line_filter.sv]
// three-stage synchroniser and agreement filter for the modem lines
`timescale 1ns/10ps
`default_nettype none
`include "break_modem_defines.svh"

module modem_line_filter (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    modem_lines_if.sync lines
);

    // ----------------------------------------
    // per-line synchroniser
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `LINE_COUNT; i++) begin : g_line
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic clean_q;
            // s1 feeds only s2, so metastability never reaches a gate
            always_ff @(posedge clk_sys_in) begin
                if (!nrst_in) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= lines.raw[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // a change counts once stages two and three agree
            always_ff @(posedge clk_sys_in) begin
                if (!nrst_in) begin
                    clean_q <= 1'b0;
                end else if (s2_q == s3_q) begin
                    clean_q <= s3_q;
                end
            end
            assign lines.clean[i] = clean_q;
        end
    endgenerate

endmodule

`default_nettype wire

// [tb/modem_partner.sv]
// behavioural answering modem on the far side of the control lines
`timescale 1ns/10ps
`default_nettype none
module modem_partner (
    input wire logic clk_in,
    input wire logic dtr_in,
    input wire logic rts_in,
    input wire logic call_in,
    input wire logic carrier_in,
    input wire logic [3:0] lag_in,
    output logic cts_out,
    output logic dsr_out,
    output logic dcd_out
);
    logic [3:0] n_q;
    logic answer;
    // --------
    // answer only a remote call, hang up when terminal ready drops
    // --------
    assign answer = dtr_in && rts_in && call_in;
    assign cts_out = answer;
    assign dsr_out = answer;
    // lag lets the carrier come up slowly after the answer
    assign dcd_out = answer && carrier_in && (n_q >= lag_in);
    always_ff @(posedge clk_in) begin
        n_q <= !answer ? 4'h0 : (n_q == 4'hf) ? n_q : n_q + 4'h1;
    end
endmodule
`default_nettype wire

// [tb/break_mask_and_modem_sequencer_props.sv]
// assertions on the break gating and modem sequencing ports
`timescale 1ns/10ps
`default_nettype none
module bmms_chk #(
    parameter logic [31:0] WAIT_CYCLES = 40,
    parameter logic [31:0] HOLD_CYCLES = 20,
    parameter logic [31:0] LOSS_CYCLES = 10
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic mask_wr_in,
    input wire break_modem_pkg::mask_type mask_data_in,
    input wire logic uart_parity_err_in,
    input wire logic uart_overrun_err_in,
    input wire logic uart_framing_err_in,
    input wire logic alarm_match_in,
    input wire logic msg_not_exec_in,
    input wire logic modem_mode_in,
    input wire logic dsr_in,
    input wire logic dcd_in,
    input wire logic dtr_out,
    input wire logic rts_out,
    input wire logic break_out,
    input wire logic cmd_refuse_out,
    input wire logic connected_out
);
    import break_modem_pkg::*;
    mask_type m_q;
    logic [31:0] h_q, w_q, l_q;
    logic io_err;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // --------
    // shadow mask and run-length counters
    // --------
    assign io_err = uart_parity_err_in || uart_overrun_err_in || uart_framing_err_in;
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) m_q <= 8'h00;
        else if (mask_wr_in && !cmd_refuse_out) m_q <= mask_data_in;
    end
    // counters restart whenever their condition breaks
    always_ff @(posedge clk_sys_in) begin
        h_q <= (nrst_in && cmd_refuse_out) ? h_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys_in) begin
        w_q <= (nrst_in && dtr_out && !connected_out) ? w_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys_in) begin
        l_q <= (nrst_in && connected_out && !(dsr_in && dcd_in)) ? l_q + 32'h1 : 32'h0;
    end
    // --------
    // properties
    // --------
    a_io_err_break: assert property (m_q[0] && m_q[6] && io_err |=> break_out)
        else $error("io error gave no break");
    a_alarm_break: assert property (m_q[2] && m_q[6] && alarm_match_in |=> break_out)
        else $error("alarm gave no break");
    a_msg_break: assert property (m_q[4] && m_q[6] && msg_not_exec_in |=> break_out)
        else $error("unexecuted message gave no break");
    a_master_gate: assert property (!m_q[6] |=> !break_out)
        else $error("break without master enable");
    a_hold_dtr_low: assert property (cmd_refuse_out |-> !dtr_out && !connected_out)
        else $error("terminal ready up during hold");
    a_hold_bound: assert property (cmd_refuse_out |-> h_q < HOLD_CYCLES)
        else $error("hold too long");
    a_hold_exact: assert property ($fell(cmd_refuse_out) && modem_mode_in
        |-> $past(h_q) == HOLD_CYCLES - 1 && dtr_out)
        else $error("hold length or recovery wrong");
    a_wait_timeout: assert property ($rose(cmd_refuse_out) && !$past(connected_out)
        |-> $past(w_q) inside {[WAIT_CYCLES - 2:WAIT_CYCLES]})
        else $error("connect wait timeout wrong");
    a_loss_bound: assert property (connected_out |-> l_q <= LOSS_CYCLES + 8)
        else $error("line loss not acted on");
    a_rts_with_dtr: assert property (dtr_out |-> rts_out)
        else $error("terminal ready without request to send");
    a_direct_idle: assert property (!modem_mode_in [*2] |-> !dtr_out && !rts_out)
        else $error("modem lines driven in direct mode");
    c_break: cover property (break_out);
    c_connect: cover property ($rose(connected_out));
    c_hold_end: cover property ($fell(cmd_refuse_out));
endmodule
bind break_mask_and_modem_sequencer bmms_chk #(.WAIT_CYCLES(WAIT_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) chk (.clk_sys_in, .nrst_in,
    .mask_wr_in, .mask_data_in, .uart_parity_err_in, .uart_overrun_err_in,
    .uart_framing_err_in, .alarm_match_in, .msg_not_exec_in, .modem_mode_in, .dsr_in,
    .dcd_in, .dtr_out, .rts_out, .break_out, .cmd_refuse_out, .connected_out);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the break mask and modem sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import break_modem_pkg::*;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic mask_wr_in = 1'b0;
    mask_type mask_data_in = 8'h00;
    logic [7:0] s = 8'h00;
    logic modem_mode_in = 1'b0;
    logic call = 1'b0;
    logic carrier = 1'b0;
    logic [3:0] lag = 4'h5;
    logic cts_in, dsr_in, dcd_in, dtr_out, rts_out, break_out, cmd_refuse_out, connected_out;
    logic [2:0] watch;
    integer miscompares = 0;
    integer tests_run = 0;
    integer seed = 32'h24db3a2d;
    integer i, n;
    mask_type codes [6] = '{8'h48, 8'h44, 8'h42, 8'h41, 8'h60, 8'h50};
    assign watch = {connected_out, cmd_refuse_out, dtr_out};
    break_mask_and_modem_sequencer #(.WAIT_CYCLES(40), .HOLD_CYCLES(20), .LOSS_CYCLES(10)) uut (
        .clk_sys_in, .nrst_in, .mask_wr_in, .mask_data_in,
        .uart_parity_err_in(s[0]), .digital_intr_in(s[1]), .alarm_match_in(s[2]),
        .interval_expired_in(s[3]), .msg_not_exec_in(s[4]), .extender_recovered_in(s[5]),
        .uart_overrun_err_in(s[6]), .uart_framing_err_in(s[7]), .modem_mode_in,
        .cts_in, .dsr_in, .dcd_in, .dtr_out, .rts_out, .break_out, .cmd_refuse_out,
        .connected_out);
    modem_partner peer (.clk_in(clk_sys_in), .dtr_in(dtr_out), .rts_in(rts_out),
        .call_in(call), .carrier_in(carrier), .lag_in(lag), .cts_out(cts_in),
        .dsr_out(dsr_in), .dcd_out(dcd_in));
    // --------
    // helpers
    // --------
    function automatic logic exp_break(input mask_type m, input logic [7:0] src);
        exp_break = m[6] & |(m[5:0] & {src[5:1], src[0] | src[6] | src[7]});
    endfunction
    task automatic check_count(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_count({31'h0, got}, {31'h0, exp});
    endtask
    // bounded wait on one watched status line, counted in cycles
    task automatic wait_level(input int idx, input logic lvl, output integer cnt);
        cnt = 0;
        while (watch[idx] !== lvl && cnt < 200) begin
            @(negedge clk_sys_in);
            cnt++;
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // --------
    // clock, watchdog, stimulus
    // --------
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // run needs about 1000 cycles, so 5000 means a hang
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (5) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        // direct mode: documented codes and random masks against single sources
        for (i = 0; i < 300; i++) begin
            @(negedge clk_sys_in);
            check_bit(break_out, 1'b0);
            mask_wr_in = 1'b1;
            mask_data_in = (i % 2) ? 8'($random(seed)) : codes[i % 6];
            @(negedge clk_sys_in);
            mask_wr_in = 1'b0;
            s = 8'h01 << ($random(seed) & 32'h7);
            @(negedge clk_sys_in);
            check_bit(break_out, exp_break(mask_data_in, s));
            s = 8'h00;
        end
        // modem mode with no caller: timeout, hold, refused write, recovery
        mask_wr_in = 1'b1;
        mask_data_in = 8'h41;
        modem_mode_in = 1'b1;
        @(negedge clk_sys_in);
        mask_wr_in = 1'b0;
        @(negedge clk_sys_in);
        check_bit(dtr_out, 1'b1);
        check_bit(rts_out, 1'b1);
        wait_level(1, 1'b1, n);
        check_bit(n >= 37 && n <= 40, 1'b1);
        check_bit(break_out, 1'b1);
        @(negedge clk_sys_in);
        check_bit(break_out, 1'b0);
        mask_wr_in = 1'b1;
        mask_data_in = 8'h00;
        @(negedge clk_sys_in);
        mask_wr_in = 1'b0;
        check_bit(dtr_out, 1'b0);
        wait_level(1, 1'b0, n);
        check_count(n, 32'd18);
        check_bit(dtr_out, 1'b1);
        s = 8'h01;
        @(negedge clk_sys_in);
        s = 8'h00;
        check_bit(break_out, 1'b1);
        // remote call with slow carrier, short dropout, then real loss
        call = 1'b1;
        carrier = 1'b1;
        wait_level(2, 1'b1, n);
        check_bit(n < 30, 1'b1);
        carrier = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        carrier = 1'b1;
        repeat (15) @(negedge clk_sys_in);
        check_bit(connected_out, 1'b1);
        carrier = 1'b0;
        wait_level(1, 1'b1, n);
        check_bit(n >= 10 && n <= 18, 1'b1);
        modem_mode_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check_bit(dtr_out, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
